// ==== src/bisc_consts.svh ====
// register offsets, field positions, reset values and codes of the
// bridge interrupt cause and control block.
// assumes inclusion by bare name from every design file that needs it.
`ifndef BISC_CONSTS_SVH
`define BISC_CONSTS_SVH

// register map (byte addresses, low address bits only)
`define BISC_ADDR_W       12
`define BISC_OFF_CTRL     12'h134
`define BISC_OFF_CAUSE    12'h138
`define BISC_OFF_MASK     12'h13C

// status/control fields
`define BISC_CTRL_BUSY    0
`define BISC_CTRL_GDIS    8
`define BISC_CTRL_CLRW    16
`define BISC_CTRL_ROW     17
`define BISC_CTRL_WMASK   32'h0003_0100
`define BISC_CTRL_RST     32'h0000_0000

// cause register layout
`define BISC_CAUSE_RST    32'h0000_0000
`define BISC_CAUSE_IMPL   32'h1FF3_0FEF
`define BISC_CAUSE_ERR    32'h0000_0E00
`define BISC_EV_LINK      0
`define BISC_EV_ECRC      1
`define BISC_EV_STRM      2
`define BISC_EV_HOTR      3
`define BISC_EV_CFGST     5
`define BISC_EV_CFGTO     8
`define BISC_EV_COR       9
`define BISC_EV_NF        10
`define BISC_EV_FAT       11
`define BISC_EV_INTX      16
`define BISC_EV_MSI       17
`define BISC_EV_UR        20
`define BISC_EV_UNEXP     21
`define BISC_EV_CTO       22
`define BISC_EV_EP        23
`define BISC_EV_CA        24
`define BISC_EV_BURST     25
`define BISC_EV_DEC       26
`define BISC_EV_SLV       27
`define BISC_EV_MWP       28

// enable mask layout
`define BISC_MASK_RST     32'h0000_0000
`define BISC_MASK_WBASE   32'h1FF0_0005
`define BISC_MASK_EPONLY  32'h0000_000A
`define BISC_MASK_RPONLY  32'h0003_0FE0

// codes seen on the event inputs
`define BISC_CPL_UR       3'h1
`define BISC_CPL_CA       3'h4
`define BISC_BURST_INCR   2'h1
`define BISC_RESP_SLVERR  2'h2
`define BISC_RESP_DECERR  2'h3

// bus constants
`define BISC_HTRANS_ACT   1
`define BISC_HRESP_OKAY   1'h0

`endif

// ==== src/bisc_pkg.sv ====
// types shared by the bridge interrupt cause and control block.
// assumes nothing beyond a SystemVerilog compiler.
package bisc_pkg;

	typedef logic [31:0] bisc_word_t;
	typedef logic [11:0] bisc_addr_t;
	typedef logic [2:0]  bisc_cpl_st_t;
	typedef logic [1:0]  bisc_axi_t;

endpackage : bisc_pkg

// ==== src/bisc_link_watch.sv ====
// link loss detector: one-cycle pulse when an established link drops.
// assumes link_up is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module bisc_link_watch
(
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// link state
	input  wire logic link_up,
	// event
	output logic      loss
);

	logic up_q;

	// only a link seen up can be lost
	always_ff @(posedge clk)
	begin
		if (!nrst)
			up_q <= 1'b0;
		else
			up_q <= link_up;
	end

	assign loss = up_q & ~link_up; // [RULE8]

	sequence s_up_then_down;
		link_up ##1 !link_up;
	endsequence

	a_loss_after_up: assert property ( // [RULE8]
		@(posedge clk) disable iff (!nrst)
		s_up_then_down |-> loss)
		else $error("link loss not flagged");

	a_no_loss_unseen: assert property ( // [RULE8]
		@(posedge clk) disable iff (!nrst)
		(!link_up ##1 1'b1) |-> !loss)
		else $error("loss flagged without prior link up");

endmodule : bisc_link_watch

`default_nettype wire

// ==== src/bisc_resp_decode.sv ====
// decodes completion and AXI response events into cause pulses.
// assumes each valid input is a one-cycle pulse with its code.
`timescale 1ns/1ps
`default_nettype none
`include "bisc_consts.svh"

module bisc_resp_decode
(
	// completion side
	input  wire logic                 cpl_valid,
	input  wire bisc_pkg::bisc_cpl_st_t cpl_status,
	input  wire logic                 cpl_ep,
	// axi slave burst request
	input  wire logic                 slv_req,
	input  wire bisc_pkg::bisc_axi_t  slv_burst,
	// axi master response
	input  wire logic                 mst_resp_valid,
	input  wire bisc_pkg::bisc_axi_t  mst_resp,
	// decoded pulses
	output logic                      ur,
	output logic                      ca,
	output logic                      poison,
	output logic                      bad_burst,
	output logic                      dec_err,
	output logic                      tgt_err
);

	import bisc_pkg::*;

	assign ur        = cpl_valid & (cpl_status == `BISC_CPL_UR); // [RULE15]
	assign ca        = cpl_valid & (cpl_status == `BISC_CPL_CA); // [RULE19]
	assign poison    = cpl_valid & cpl_ep; // [RULE18]
	assign bad_burst = slv_req & (slv_burst != `BISC_BURST_INCR); // [RULE20]
	assign dec_err   = mst_resp_valid
		& (mst_resp == `BISC_RESP_DECERR); // [RULE21]
	assign tgt_err   = mst_resp_valid
		& (mst_resp == `BISC_RESP_SLVERR); // [RULE21]

endmodule : bisc_resp_decode

`default_nettype wire

// ==== src/bisc_irq_ctrl.sv ====
// bridge interrupt cause/control block with an AHB-Lite register slave.
// assumes event inputs are one-cycle pulses synchronous to clk and
// that a single master drives the bus, hready fed back from hreadyout.
// Operation
// [RULE1] access-pending status bit always reads zero
// [RULE2] global disable blocks line, causes still latch
// [RULE3] clear-writable mode stores written cause value
// [RULE4] readonly-writable mode opens read-only mask bits; here only in endpoint role, bits 1 and 3 stay read-only in root port role
// [RULE5] write one clears cause; error bits special
// [RULE6] software drains error FIFO before clearing errors
// [RULE7] cause drives line only when mask set
// [RULE8] bit 0 on loss of seen link
// [RULE9] bit 1 on end-to-end CRC failure
// [RULE10] bit 2 on transmit stream gap
// [RULE11] bit 3 on link hot reset
// [RULE12] root port: config status, config timeout
// [RULE13] root port: error messages set 9-11
// [RULE14] root port: legacy 16, message 17
// [RULE15] bit 20 on unsupported request completion
// [RULE16] bit 21 on unexpected completion
// [RULE17] bit 22 on completion timeout
// [RULE18] bit 23 on poisoned completion
// [RULE19] bit 24 on completer abort completion
// [RULE20] bit 25 on non-incrementing slave burst
// [RULE21] bits 26-28 on master errors, poisoned write
// [RULE22] mask resets to zero
// [RULE23] line is masked causes OR, gated
// [RULE24] reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "bisc_consts.svh"

module bisc_irq_ctrl
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// ahb-lite slave
	input  wire logic                   hsel,
	input  wire bisc_pkg::bisc_word_t   haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic                   hready,
	input  wire bisc_pkg::bisc_word_t   hwdata,
	output var  bisc_pkg::bisc_word_t   hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// configuration strap and error FIFO status
	input  wire logic                   root_port_en,
	input  wire logic                   err_fifo_empty,
	// link events
	input  wire logic                   link_up,
	input  wire logic                   ecrc_err,
	input  wire logic [2:0]             tx_stream_gap,
	input  wire logic                   hot_reset,
	// root port events
	input  wire logic                   cfg_cpl_valid,
	input  wire bisc_pkg::bisc_cpl_st_t cfg_cpl_status,
	input  wire logic                   cfg_timeout,
	input  wire logic                   err_msg_cor,
	input  wire logic                   err_msg_nonfatal,
	input  wire logic                   err_msg_fatal,
	input  wire logic                   intx_rcvd,
	input  wire logic                   msi_rcvd,
	// completion tracking events
	input  wire logic                   cpl_valid,
	input  wire bisc_pkg::bisc_cpl_st_t cpl_status,
	input  wire logic                   cpl_ep,
	input  wire logic                   cpl_unexpected,
	input  wire logic                   cpl_timeout,
	// axi path events
	input  wire logic                   slv_req,
	input  wire bisc_pkg::bisc_axi_t    slv_burst,
	input  wire logic                   mst_resp_valid,
	input  wire bisc_pkg::bisc_axi_t    mst_resp,
	input  wire logic                   memwr_poison,
	// interrupt line
	output logic                        irq
);

	import bisc_pkg::*;

	function automatic logic reg_hit(input bisc_addr_t a,
		input bisc_addr_t off);
		return a == off;
	endfunction : reg_hit

	bisc_word_t ctrl_q;
	bisc_word_t ctrl_d;
	bisc_word_t cause_q;
	bisc_word_t cause_d;
	bisc_word_t mask_q;
	bisc_word_t mask_d;
	bisc_word_t mask_wen;
	bisc_word_t ev_set;
	bisc_word_t rd_d;
	bisc_addr_t dp_addr_q;
	logic       dp_wr_q;
	logic       ap_take;
	logic       wr_ctrl;
	logic       wr_cause;
	logic       wr_mask;
	logic       global_dis;
	logic       clear_bits_writable;
	logic       readonly_bits_writable;
	logic       irq_d;
	logic       link_loss;
	logic       ev_ur;
	logic       ev_ca;
	logic       ev_poison;
	logic       ev_burst;
	logic       ev_dec;
	logic       ev_tgt;

	bisc_link_watch u_link
	(
		.clk     (clk),
		.nrst    (nrst),
		.link_up (link_up),
		.loss    (link_loss)
	);

	bisc_resp_decode u_resp
	(
		.cpl_valid      (cpl_valid),
		.cpl_status     (cpl_status),
		.cpl_ep         (cpl_ep),
		.slv_req        (slv_req),
		.slv_burst      (slv_burst),
		.mst_resp_valid (mst_resp_valid),
		.mst_resp       (mst_resp),
		.ur             (ev_ur),
		.ca             (ev_ca),
		.poison         (ev_poison),
		.bad_burst      (ev_burst),
		.dec_err        (ev_dec),
		.tgt_err        (ev_tgt)
	);

	// bus address phase: any size is taken as a whole word
	assign ap_take = hsel & htrans[`BISC_HTRANS_ACT] & hready;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= '0;
		end
		else
		begin
			dp_wr_q   <= ap_take & hwrite;
			dp_addr_q <= haddr[`BISC_ADDR_W-1:0];
		end
	end

	// unmapped addresses fall through all three hits
	assign wr_ctrl  = dp_wr_q & reg_hit(dp_addr_q, `BISC_OFF_CTRL);
	assign wr_cause = dp_wr_q & reg_hit(dp_addr_q, `BISC_OFF_CAUSE);
	assign wr_mask  = dp_wr_q & reg_hit(dp_addr_q, `BISC_OFF_MASK);

	// zero wait states, always OKAY
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			hreadyout <= 1'b0;
			hresp     <= `BISC_HRESP_OKAY;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= `BISC_HRESP_OKAY;
		end
	end

	// status/control: busy bit never stored, reserved bits dropped
	assign ctrl_d = wr_ctrl ? (hwdata & `BISC_CTRL_WMASK)
		: ctrl_q; // [RULE1] [RULE24]

	always_ff @(posedge clk)
	begin
		if (!nrst)
			ctrl_q <= `BISC_CTRL_RST;
		else
			ctrl_q <= ctrl_d;
	end

	assign global_dis             = ctrl_q[`BISC_CTRL_GDIS];
	assign clear_bits_writable    = ctrl_q[`BISC_CTRL_CLRW];
	assign readonly_bits_writable = ctrl_q[`BISC_CTRL_ROW];

	// event collection
	always_comb
	begin
		ev_set = '0;
		ev_set[`BISC_EV_LINK]  = link_loss; // [RULE8]
		ev_set[`BISC_EV_ECRC]  = ecrc_err; // [RULE9]
		ev_set[`BISC_EV_STRM]  = |tx_stream_gap; // [RULE10]
		ev_set[`BISC_EV_HOTR]  = hot_reset; // [RULE11]
		ev_set[`BISC_EV_CFGST +: 3] = (cfg_cpl_valid & root_port_en)
			? cfg_cpl_status : 3'h0; // [RULE12]
		ev_set[`BISC_EV_CFGTO] = cfg_timeout & root_port_en; // [RULE12]
		ev_set[`BISC_EV_COR]   = err_msg_cor & root_port_en; // [RULE13]
		ev_set[`BISC_EV_NF]    = err_msg_nonfatal & root_port_en; // [RULE13]
		ev_set[`BISC_EV_FAT]   = err_msg_fatal & root_port_en; // [RULE13]
		ev_set[`BISC_EV_INTX]  = intx_rcvd & root_port_en; // [RULE14]
		ev_set[`BISC_EV_MSI]   = msi_rcvd & root_port_en; // [RULE14]
		ev_set[`BISC_EV_UR]    = ev_ur; // [RULE15]
		ev_set[`BISC_EV_UNEXP] = cpl_unexpected; // [RULE16]
		ev_set[`BISC_EV_CTO]   = cpl_timeout; // [RULE17]
		ev_set[`BISC_EV_EP]    = ev_poison; // [RULE18]
		ev_set[`BISC_EV_CA]    = ev_ca; // [RULE19]
		ev_set[`BISC_EV_BURST] = ev_burst; // [RULE20]
		ev_set[`BISC_EV_DEC]   = ev_dec; // [RULE21]
		ev_set[`BISC_EV_SLV]   = ev_tgt; // [RULE21]
		ev_set[`BISC_EV_MWP]   = memwr_poison; // [RULE21]
	end

	// cause register; a new event always beats a clear in the same cycle
	always_comb
	begin
		bisc_word_t clr;
		clr     = '0;
		cause_d = cause_q;
		if (wr_cause)
		begin
			if (clear_bits_writable)
				cause_d = hwdata & `BISC_CAUSE_IMPL; // [RULE3]
			else
			begin
				clr = hwdata & `BISC_CAUSE_IMPL & ~`BISC_CAUSE_ERR; // [RULE5]
				// error bits stay while the error FIFO still holds entries
				if (err_fifo_empty)
					clr = clr | (hwdata & `BISC_CAUSE_ERR); // [RULE5] [RULE6]
				cause_d = cause_q & ~clr;
			end
		end
		cause_d = cause_d | ev_set; // [RULE2] [RULE24]
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			cause_q <= `BISC_CAUSE_RST;
		else
			cause_q <= cause_d;
	end

	// mask: which bits take writes depends on the port role
	always_comb
	begin
		mask_wen = `BISC_MASK_WBASE;
		if (!root_port_en)
			mask_wen = mask_wen | `BISC_MASK_EPONLY;
		if (root_port_en | readonly_bits_writable)
			mask_wen = mask_wen | `BISC_MASK_RPONLY; // [RULE4]
		mask_d = wr_mask ? ((hwdata & mask_wen) | (mask_q & ~mask_wen))
			: mask_q;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			mask_q <= `BISC_MASK_RST; // [RULE22]
		else
			mask_q <= mask_d;
	end

	// read data built from next values so a write just before is seen
	always_comb
	begin
		if (reg_hit(haddr[`BISC_ADDR_W-1:0], `BISC_OFF_CTRL))
			rd_d = ctrl_d; // [RULE1]
		else if (reg_hit(haddr[`BISC_ADDR_W-1:0], `BISC_OFF_CAUSE))
			rd_d = cause_d;
		else if (reg_hit(haddr[`BISC_ADDR_W-1:0], `BISC_OFF_MASK))
			rd_d = mask_d;
		else
			rd_d = '0;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			hrdata <= '0;
		else if (ap_take & ~hwrite)
			hrdata <= rd_d;
	end

	// interrupt line, one flop after the cause and mask
	assign irq_d = (|(cause_q & mask_q)) & ~global_dis; // [RULE7] [RULE23]

	always_ff @(posedge clk)
	begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= irq_d; // [RULE2]
	end

	sequence s_cause_write(logic mode);
		wr_cause && (clear_bits_writable == mode) && (ev_set == '0);
	endsequence

	a_busy_reads_zero: assert property ( // [RULE1]
		@(posedge clk) disable iff (!nrst)
		(ap_take && !hwrite
			&& reg_hit(haddr[`BISC_ADDR_W-1:0], `BISC_OFF_CTRL))
		|=> (hrdata[`BISC_CTRL_BUSY] == 1'b0))
		else $error("access pending bit read as one");

	a_gdis_blocks_irq: assert property ( // [RULE2]
		@(posedge clk) disable iff (!nrst)
		global_dis |=> !irq)
		else $error("line asserted under global disable");

	a_gdis_still_latch: assert property ( // [RULE2]
		@(posedge clk) disable iff (!nrst)
		(global_dis && ev_set != '0)
		|=> ((cause_q & $past(ev_set)) == $past(ev_set)))
		else $error("cause lost under global disable");

	a_rw_mode_store: assert property ( // [RULE3]
		@(posedge clk) disable iff (!nrst)
		s_cause_write(1'b1)
		|=> cause_q == ($past(hwdata) & `BISC_CAUSE_IMPL))
		else $error("cause not stored in writable mode");

	a_w1c_clears: assert property ( // [RULE5]
		@(posedge clk) disable iff (!nrst)
		s_cause_write(1'b0)
		|=> (cause_q & $past(hwdata) & ~`BISC_CAUSE_ERR) == '0)
		else $error("write one did not clear cause");

	a_err_held: assert property ( // [RULE5]
		@(posedge clk) disable iff (!nrst)
		(wr_cause && !clear_bits_writable && !err_fifo_empty)
		|=> ((cause_q & $past(cause_q) & `BISC_CAUSE_ERR)
			== ($past(cause_q) & `BISC_CAUSE_ERR)))
		else $error("error bit cleared with fifo not empty");

	a_mask_gates: assert property ( // [RULE7]
		@(posedge clk) disable iff (!nrst)
		((cause_q & mask_q) == '0) |=> !irq)
		else $error("line asserted with no enabled cause");

	a_irq_follows: assert property ( // [RULE23]
		@(posedge clk) disable iff (!nrst)
		((cause_q & mask_q) != '0 && !global_dis) |=> irq)
		else $error("line missing for enabled cause");

	a_mask_reset: assert property ( // [RULE22]
		@(posedge clk)
		!nrst |=> (mask_q == '0 && !irq))
		else $error("mask not zero after reset");

	a_reserved_zero: assert property ( // [RULE24] [RULE1]
		@(posedge clk) disable iff (!nrst)
		((cause_q & ~`BISC_CAUSE_IMPL) == '0)
		&& ((ctrl_q & ~`BISC_CTRL_WMASK) == '0))
		else $error("reserved bit set");

endmodule : bisc_irq_ctrl

`default_nettype wire

// ==== bench/bisc_host.sv ====
// ahb-lite host model: single word transfers, error-clear routine.
// assumes hready is the one slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none

module bisc_host
(
	// clock and status
	input  wire logic                 clk,
	input  wire logic                 err_empty,
	// slave answer
	input  wire logic                 hready,
	input  wire bisc_pkg::bisc_word_t hrdata,
	// request
	output logic                      hsel,
	output bisc_pkg::bisc_word_t      haddr,
	output logic [1:0]                htrans,
	output logic                      hwrite,
	output logic [2:0]                hsize,
	output bisc_pkg::bisc_word_t      hwdata
);
	import bisc_pkg::*;

	initial
	begin
		hsel   = 1'h0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize  = 3'h2;
		hwdata = 32'h0;
	end

	// each phase held until hready is seen high at an edge
	task automatic xfer(input logic w, input bisc_word_t a,
		input bisc_word_t d, output bisc_word_t r);
		@(posedge clk);
		hsel   <= 1'h1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
		r = hrdata;
	endtask : xfer

	// error causes cleared once the error queue is drained, or after 100 cycles of waiting
	task automatic clr_err(input bisc_word_t m);
		bisc_word_t r;
		for (int i = 0; i < 100 && err_empty !== 1'h1; i++)
			@(posedge clk);
		xfer(1'h1, 32'h138, m, r);
	endtask : clr_err

endmodule : bisc_host
`default_nettype wire

// ==== bench/bisc_irq_ctrl_tb.sv ====
// self-checking bench of the interrupt cause/control block.
// assumes the host model owns the bus; events are driven from here.
`timescale 1ns/1ps
`default_nettype none
`include "bisc_consts.svh"

module bisc_irq_ctrl_tb;
	import bisc_pkg::*;

	typedef struct packed
	{
		logic [15:0] ev;
		logic [2:0]  gap;
		logic [2:0]  code;
		bisc_word_t  exp;
	} bisc_row_t;

	localparam bisc_word_t ra_ctrl  = {20'h0, `BISC_OFF_CTRL};
	localparam bisc_word_t ra_cause = {20'h0, `BISC_OFF_CAUSE};
	localparam bisc_word_t ra_mask  = {20'h0, `BISC_OFF_MASK};
	// one event per row; the code feeds status, burst and response
	localparam bisc_row_t rows [25] = '{
		'{16'h0002, 3'h0, 3'h0, 32'h2}, '{16'h0000, 3'h1, 3'h0, 32'h4},
		'{16'h0000, 3'h2, 3'h0, 32'h4}, '{16'h0000, 3'h4, 3'h0, 32'h4},
		'{16'h0004, 3'h0, 3'h0, 32'h8}, '{16'h0008, 3'h0, 3'h5, 32'hA0},
		'{16'h0010, 3'h0, 3'h0, 32'h100}, '{16'h0020, 3'h0, 3'h0, 32'h200},
		'{16'h0040, 3'h0, 3'h0, 32'h400}, '{16'h0080, 3'h0, 3'h0, 32'h800},
		'{16'h0100, 3'h0, 3'h0, 32'h10000},
		'{16'h0200, 3'h0, 3'h0, 32'h20000},
		'{16'h0400, 3'h0, 3'h1, 32'h100000},
		'{16'h0400, 3'h0, 3'h4, 32'h1000000},
		'{16'h0400, 3'h0, 3'h2, 32'h0},
		'{16'h0401, 3'h0, 3'h0, 32'h800000},
		'{16'h0800, 3'h0, 3'h0, 32'h200000},
		'{16'h1000, 3'h0, 3'h0, 32'h400000},
		'{16'h2000, 3'h0, 3'h0, 32'h2000000},
		'{16'h2000, 3'h0, 3'h1, 32'h0},
		'{16'h2000, 3'h0, 3'h2, 32'h2000000},
		'{16'h4000, 3'h0, 3'h3, 32'h4000000},
		'{16'h4000, 3'h0, 3'h2, 32'h8000000},
		'{16'h4000, 3'h0, 3'h0, 32'h0},
		'{16'h8000, 3'h0, 3'h0, 32'h10000000}};

	logic        clk = 1'h0;
	logic        nrst = 1'h0;
	logic        rp_en = 1'h1;
	logic        fifo_empty = 1'h1;
	logic        link_up = 1'h0;
	logic [15:0] ev = 16'h0;
	logic [2:0]  gap = 3'h0;
	logic [2:0]  code = 3'h0;
	logic        hsel, hwrite, hreadyout, hresp, irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	bisc_word_t  haddr, hwdata, hrdata, rdat;
	int          n_fail = 0;
	int          total_checks = 0;

	always #2 clk = ~clk;

	bisc_irq_ctrl i_dut (.clk(clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .root_port_en(rp_en),
		.err_fifo_empty(fifo_empty), .link_up(link_up),
		.ecrc_err(ev[1]), .tx_stream_gap(gap), .hot_reset(ev[2]),
		.cfg_cpl_valid(ev[3]), .cfg_cpl_status(code),
		.cfg_timeout(ev[4]), .err_msg_cor(ev[5]),
		.err_msg_nonfatal(ev[6]), .err_msg_fatal(ev[7]),
		.intx_rcvd(ev[8]), .msi_rcvd(ev[9]), .cpl_valid(ev[10]),
		.cpl_status(code), .cpl_ep(ev[0]), .cpl_unexpected(ev[11]),
		.cpl_timeout(ev[12]), .slv_req(ev[13]), .slv_burst(code[1:0]),
		.mst_resp_valid(ev[14]), .mst_resp(code[1:0]),
		.memwr_poison(ev[15]), .irq(irq));

	bisc_host i_host (.clk(clk), .err_empty(fifo_empty),
		.hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	task automatic chk_w(input bisc_word_t got, input bisc_word_t exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %0t: word %h, want %h", $time, got, exp);
		end
	endtask : chk_w

	task automatic chk_b(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %0t: bit %b, want %b", $time, got, exp);
		end
	endtask : chk_b

	task automatic wr(input bisc_word_t a, input bisc_word_t d);
		i_host.xfer(1'h1, a, d, rdat);
	endtask : wr

	task automatic rd_chk(input bisc_word_t a, input bisc_word_t exp);
		i_host.xfer(1'h0, a, 32'h0, rdat);
		chk_w(rdat, exp);
	endtask : rd_chk

	// one-cycle event, then sample one cycle past the latch edge
	task automatic pulse(input bisc_row_t r);
		@(posedge clk);
		ev   <= r.ev;
		gap  <= r.gap;
		code <= r.code;
		@(posedge clk);
		ev  <= 16'h0;
		gap <= 3'h0;
		@(posedge clk);
		#1;
	endtask : pulse

	task automatic results;
		if (n_fail == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		results();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		rd_chk(ra_mask, 32'h0);
		wr(ra_mask, 32'hFFFFFFFF);
		rd_chk(ra_mask, 32'h1FF30FE5);
		foreach (rows[i])
		begin
			pulse(rows[i]);
			chk_b(irq, |(rows[i].exp & 32'h1FF30FE5));
			rd_chk(ra_cause, rows[i].exp);
			wr(ra_cause, rows[i].exp);
			rd_chk(ra_cause, 32'h0);
			chk_b(irq, 1'h0);
		end
		// global disable keeps the line low but the cause still latches
		wr(ra_ctrl, 32'h100);
		pulse(rows[6]);
		chk_b(irq, 1'h0);
		rd_chk(ra_cause, 32'h100);
		wr(ra_ctrl, 32'h0);
		@(posedge clk);
		#1;
		chk_b(irq, 1'h1);
		wr(ra_mask, 32'h0);
		@(posedge clk);
		#1;
		chk_b(irq, 1'h0);
		wr(ra_ctrl, 32'hFFFFFFFF);
		rd_chk(ra_ctrl, 32'h30100);
		wr(ra_cause, 32'hFFFFFFFF);
		rd_chk(ra_cause, 32'h1FF30FEF);
		wr(ra_cause, 32'h0);
		rd_chk(ra_cause, 32'h0);
		// endpoint role: read-only enables opened by the debug bit
		wr(ra_ctrl, 32'h20000);
		@(posedge clk);
		rp_en <= 1'h0;
		wr(ra_mask, 32'hFFFFFFFF);
		rd_chk(ra_mask, 32'h1FF30FEF);
		pulse(rows[10]);
		rd_chk(ra_cause, 32'h0);
		// error cause survives a clear while the queue is not empty
		@(posedge clk);
		rp_en      <= 1'h1;
		fifo_empty <= 1'h0;
		pulse(rows[7]);
		wr(ra_cause, 32'h200);
		rd_chk(ra_cause, 32'h200);
		@(posedge clk);
		fifo_empty <= 1'h1;
		i_host.clr_err(32'h200);
		rd_chk(ra_cause, 32'h0);
		// link loss flags only after link-up was seen
		@(posedge clk);
		link_up <= 1'h1;
		@(posedge clk);
		link_up <= 1'h0;
		repeat (2) @(posedge clk);
		rd_chk(ra_cause, 32'h1);
		rd_chk(32'h100, 32'h0);
		chk_b(hresp, 1'h0);
		// second reset in mid-run
		@(posedge clk);
		nrst <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		chk_b(irq, 1'h0);
		chk_b(hreadyout, 1'h0);
		@(posedge clk);
		nrst <= 1'h1;
		rd_chk(ra_ctrl, 32'h0);
		rd_chk(ra_cause, 32'h0);
		rd_chk(ra_mask, 32'h0);
		results();
	end

endmodule : bisc_irq_ctrl_tb
`default_nettype wire
